// *** src/cpb_pkg.sv ***
// Shared constants and types of the controller parameter bank
package cpb_pkg;
  localparam int CLK_HZ = 100_000_000;
  // Calibration key and readback codes
  localparam logic [15:0] CAL_KEY_VALUE = 16'hCAFE;
  localparam logic [15:0] CAL_PASS_WORD = 16'hFFFF;
  localparam logic [15:0] CAL_FAIL_WORD = 16'h0000;
  localparam logic [2:0] CAL_PHASE_MIN = 3'h1;
  localparam logic [2:0] CAL_PHASE_MAX = 3'h5;
  localparam logic [2:0] CAL_PHASE_RST = 3'h1;
  // Firmware version word layout
  localparam int FW_REV_LSB = 0;
  localparam int FW_ALPHA_LSB = 5;
  localparam int FW_NUM_LSB = 10;
  localparam logic [5:0] FW_NUM_SINGLE = 6'h00;
  localparam logic [5:0] FW_NUM_MULTI = 6'h02;
  // Status word: heater alarms or outputs four to six from here up
  localparam int ST_RESERVED_BIT = 3;
  localparam int ST_UPPER_LSB = 13;
  // Configuration port baud codes, 0..7 = 1200..115200
  localparam logic [2:0] BAUD_CODE_RST = 3'h6;
  // Serial slave settings
  localparam logic [7:0] SLAVE_ADDR_MIN = 8'h01;
  localparam logic [7:0] SLAVE_ADDR_MAX = 8'hF7;
  localparam logic [7:0] SLAVE_ADDR_RST = 8'h60;
  typedef enum logic [1:0] {RATE_2400, RATE_4800, RATE_9600, RATE_19200}
    cpb_rate_e;
  typedef enum logic [1:0] {PAR_NONE, PAR_EVEN, PAR_ODD} cpb_parity_e;
  localparam int RATE_CYCLES_2400 = CLK_HZ / 2400;
  localparam int RATE_CYCLES_4800 = CLK_HZ / 4800;
  localparam int RATE_CYCLES_9600 = CLK_HZ / 9600;
  localparam int RATE_CYCLES_19200 = CLK_HZ / 19200;
  // Data assembly tables, read and write share one pool
  localparam int ASM_ENTRIES = 256;
  localparam logic [15:0] ASM_FILL = 16'hFFFF;
  localparam logic [8:0] ASM_SPLIT_RST = 9'h080;
  localparam logic [7:0] ASM_PAGE = 8'h01;
  // Parameter word addresses
  localparam logic [15:0] A_CAL_PHASE = 16'h0000;
  localparam logic [15:0] A_CAL_KEY = 16'h0001;
  localparam logic [15:0] A_LOOP_SERIAL = 16'h0002;
  localparam logic [15:0] A_FW_VERSION = 16'h0005;
  localparam logic [15:0] A_LOOP_DATE = 16'h0006;
  localparam logic [15:0] A_LOOP_PRODUCT = 16'h0009;
  localparam logic [15:0] A_LOOP_STATUS = 16'h000A;
  localparam logic [15:0] A_CFG_BAUD = 16'h000B;
  localparam logic [15:0] A_BUS_SERIAL = 16'h000C;
  localparam logic [15:0] A_BUS_DATE = 16'h000F;
  localparam logic [15:0] A_BUS_VARIANT = 16'h0012;
  localparam logic [15:0] A_DATABASE_ID = 16'h0013;
  localparam logic [15:0] A_SLAVE_ADDR = 16'h0014;
  localparam logic [15:0] A_SLAVE_RATE = 16'h0015;
  localparam logic [15:0] A_SLAVE_PARITY = 16'h0016;
  localparam logic [15:0] A_ASM_SPLIT = 16'h0017;
  // Database codes
  localparam logic [15:0] DB_MODBUS = 16'h0001;
endpackage : cpb_pkg

// *** src/cpb_asm_if.sv ***
// Port bundle between the bank and its data assembly storage
`timescale 1ns/100ps
`default_nettype none
interface cpb_asm_if #(parameter int DEPTH = 256);
  logic fill;
  logic wrEn;
  logic [$clog2(DEPTH)-1:0] wrIdx;
  logic [15:0] wrData;
  logic [$clog2(DEPTH)-1:0] rdIdx;
  logic [15:0] rdData;
  modport owner (output fill, output wrEn, output wrIdx, output wrData,
    output rdIdx, input rdData);
  modport store (input fill, input wrEn, input wrIdx, input wrData,
    input rdIdx, output rdData);
endinterface : cpb_asm_if
`default_nettype wire

// *** src/cpb_assembly_table.sv ***
// Flip-flop storage of the data assembly entries
`timescale 1ns/100ps
`default_nettype none
module cpb_assembly_table #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic reset,
  cpb_asm_if.store port
);
  import cpb_pkg::*;
  typedef struct packed {
    logic [DEPTH-1:0][15:0] entry;
  } cpb_table_s;
  cpb_table_s q;
  cpb_table_s d;

  // fill wins over any write, stale data must never show
  always_comb
  begin
    d = q;
    if (port.fill)
      d.entry = {DEPTH{ASM_FILL}};
    else if (port.wrEn)
      d.entry[port.wrIdx] = port.wrData;
  end

  // entries read all ones from reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= {DEPTH{ASM_FILL}};
    else
      q <= d;
  end

  assign port.rdData = q.entry[port.rdIdx];
endmodule : cpb_assembly_table
`default_nettype wire

// *** src/cpb_rate_divider.sv ***
// Bit-rate enable pulse for the fieldbus serial link
`timescale 1ns/100ps
`default_nettype none
module cpb_rate_divider #(
  parameter int C2400 = 41666,
  parameter int C4800 = 20833,
  parameter int C9600 = 10416,
  parameter int C19200 = 5208
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [1:0] rate,
  output logic tick
);
  import cpb_pkg::*;
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } cpb_div_s;
  cpb_div_s q;
  cpb_div_s d;

  // Reload value for a rate code, one cycle under the period
  function automatic logic [15:0] reload(input logic [1:0] r);
    unique case (cpb_rate_e'(r))
      RATE_2400: reload = 16'(C2400 - 1);
      RATE_4800: reload = 16'(C4800 - 1);
      RATE_9600: reload = 16'(C9600 - 1);
      RATE_19200: reload = 16'(C19200 - 1);
    endcase
  endfunction : reload

  // down counter gives one tick per bit time
  always_comb
  begin
    d = q;
    d.tick = 1'b0;
    if (q.count == 16'h0000)
    begin
      d.count = reload(rate);
      d.tick = 1'b1;
    end
    else
      d.count = q.count - 16'h0001;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign tick = q.tick;
endmodule : cpb_rate_divider
`default_nettype wire

// *** src/cpb_parameter_bank.sv ***
// Parameter bank of a loop-control system, seen from the fieldbus
`timescale 1ns/100ps
`default_nettype none
module cpb_parameter_bank #(
  parameter logic [39:0] LOOP_SERIAL = 40'h00_0000_0000,
  parameter logic [39:0] BUS_SERIAL = 40'h00_0000_0000,
  parameter logic [15:0] LOOP_DAY = 16'h0001,
  parameter logic [15:0] LOOP_MONTH = 16'h0001,
  parameter logic [15:0] LOOP_YEAR = 16'h0001,
  parameter logic [15:0] BUS_DAY = 16'h0001,
  parameter logic [15:0] BUS_MONTH = 16'h0001,
  parameter logic [15:0] BUS_YEAR = 16'h0001,
  // Arbitrary variant value
  parameter logic [15:0] BUS_VARIANT = 16'h0002,
  parameter logic [15:0] DATABASE_ID = cpb_pkg::DB_MODBUS,
  parameter logic [4:0] FW_REVISION = 5'h01,
  parameter logic [4:0] FW_ALPHA = 5'h00,
  parameter int C2400 = cpb_pkg::RATE_CYCLES_2400,
  parameter int C4800 = cpb_pkg::RATE_CYCLES_4800,
  parameter int C9600 = cpb_pkg::RATE_CYCLES_9600,
  parameter int C19200 = cpb_pkg::RATE_CYCLES_19200
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic powerCycle,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  output logic ansValid,
  output logic [15:0] ansData,
  output logic ansError,
  output logic calStart,
  output logic [2:0] calPhase,
  input wire logic calDone,
  input wire logic calPass,
  input wire logic [12:0] loopFlags,
  input wire logic [2:0] heaterAlarms,
  input wire logic [2:0] extraOutputs,
  input wire logic multiLoopPin,
  input wire logic moduleSwap,
  input wire logic moduleRemoved,
  input wire logic [15:0] newProductCode,
  output logic autoConfig,
  input wire logic loopWrEn,
  input wire logic [7:0] loopWrIdx,
  input wire logic [15:0] loopWrData,
  output logic [7:0] slaveAddr,
  output logic [1:0] slaveRate,
  output logic [1:0] slaveParity,
  output logic [8:0] asmSplit,
  output logic [2:0] cfgBaudCode,
  output logic bitTick
);
  import cpb_pkg::*;

  typedef struct packed {
    logic [2:0] calPhase;
    logic calBusy;
    logic calPassed;
    logic calStart;
    logic [2:0] cfgBaud;
    logic [7:0] addrStored;
    logic [7:0] addrActive;
    logic [1:0] rateStored;
    logic [1:0] rateActive;
    logic [1:0] parStored;
    logic [1:0] parActive;
    logic [8:0] splitStored;
    logic [8:0] splitActive;
    logic [15:0] product;
    logic autoCfg;
    logic [15:0] status;
    logic [1:0] multiSync;
    logic ansValid;
    logic ansError;
    logic [15:0] ansData;
  } cpb_state_s;

  cpb_state_s q;
  cpb_state_s d;
  cpb_asm_if #(.DEPTH(ASM_ENTRIES)) asmPort ();

  logic multiLoop;
  logic isAsm;
  logic [15:0] offs;
  logic [15:0] rdWord;
  logic mapped;
  logic writable;

  // Word of a 40-bit serial number, low word first
  function automatic logic [15:0] serial_word(input logic [39:0] sn,
    input logic [15:0] idx);
    case (idx[1:0])
      2'h0: serial_word = sn[15:0];
      2'h1: serial_word = sn[31:16];
      default: serial_word = {8'h00, sn[39:32]};
    endcase
  endfunction : serial_word

  // date words in day, month, year order
  function automatic logic [15:0] date_word(input logic [15:0] dy,
    input logic [15:0] mo, input logic [15:0] yr, input logic [15:0] idx);
    case (idx[1:0])
      2'h0: date_word = dy;
      2'h1: date_word = mo;
      default: date_word = yr;
    endcase
  endfunction : date_word

  assign multiLoop = q.multiSync[1];
  assign isAsm = (reqAddr[15:8] == ASM_PAGE);

  // Read side of the map
  always_comb
  begin
    rdWord = 16'h0000;
    mapped = 1'b1;
    writable = 1'b0;
    offs = 16'h0000;
    if (isAsm)
    begin
      rdWord = asmPort.rdData;
      writable = 1'b1;
    end
    else if (reqAddr >= A_LOOP_SERIAL && reqAddr < A_FW_VERSION)
    begin
      offs = reqAddr - A_LOOP_SERIAL;
      // loop serial number from fixed storage
      rdWord = serial_word(LOOP_SERIAL, offs);
    end
    else if (reqAddr >= A_LOOP_DATE && reqAddr < A_LOOP_PRODUCT)
    begin
      offs = reqAddr - A_LOOP_DATE;
      rdWord = date_word(LOOP_DAY, LOOP_MONTH, LOOP_YEAR, offs);
    end
    else if (reqAddr >= A_BUS_SERIAL && reqAddr < A_BUS_DATE)
    begin
      offs = reqAddr - A_BUS_SERIAL;
      rdWord = serial_word(BUS_SERIAL, offs);
    end
    else if (reqAddr >= A_BUS_DATE && reqAddr < A_BUS_VARIANT)
    begin
      offs = reqAddr - A_BUS_DATE;
      rdWord = date_word(BUS_DAY, BUS_MONTH, BUS_YEAR, offs);
    end
    else
    begin
      case (reqAddr)
        A_CAL_PHASE:
        begin
          rdWord = {13'h0000, q.calPhase};
          writable = 1'b1;
        end
        A_CAL_KEY:
        begin
          // pass or fail word, never the key
          rdWord = q.calPassed ? CAL_PASS_WORD : CAL_FAIL_WORD;
          writable = 1'b1;
        end
        A_FW_VERSION:
        begin
          rdWord[FW_REV_LSB +: 5] = FW_REVISION;
          rdWord[FW_ALPHA_LSB +: 5] = FW_ALPHA;
          rdWord[FW_NUM_LSB +: 6] = multiLoop ? FW_NUM_MULTI : FW_NUM_SINGLE;
        end
        A_LOOP_PRODUCT: rdWord = q.product;
        A_LOOP_STATUS: rdWord = q.status;
        A_CFG_BAUD:
        begin
          rdWord = {13'h0000, q.cfgBaud};
          writable = 1'b1;
        end
        A_BUS_VARIANT: rdWord = BUS_VARIANT;
        A_DATABASE_ID: rdWord = DATABASE_ID;
        A_SLAVE_ADDR:
        begin
          rdWord = {8'h00, q.addrStored};
          writable = 1'b1;
        end
        A_SLAVE_RATE:
        begin
          rdWord = {14'h0000, q.rateStored};
          writable = 1'b1;
        end
        A_SLAVE_PARITY:
        begin
          rdWord = {14'h0000, q.parStored};
          writable = 1'b1;
        end
        A_ASM_SPLIT:
        begin
          rdWord = {7'h00, q.splitStored};
          writable = 1'b1;
        end
        default: mapped = 1'b0;
      endcase
    end
  end

  // Assembly port: loop-side collation has priority over the master
  always_comb
  begin
    asmPort.rdIdx = reqAddr[7:0];
    // refill on power cycle, swap or removal
    asmPort.fill = powerCycle | moduleSwap | moduleRemoved;
    asmPort.wrEn = 1'b0;
    asmPort.wrIdx = reqAddr[7:0];
    asmPort.wrData = reqData;
    if (loopWrEn)
    begin
      asmPort.wrEn = 1'b1;
      asmPort.wrIdx = loopWrIdx;
      asmPort.wrData = loopWrData;
    end
    // master may only write the write-table part of the pool
    else if (reqValid && reqWrite && isAsm &&
      {1'b0, reqAddr[7:0]} >= q.splitActive)
      asmPort.wrEn = 1'b1;
  end

  // Next state of the bank
  always_comb
  begin
    logic accept;
    accept = 1'b0;
    d = q;
    d.calStart = 1'b0;
    d.autoCfg = 1'b0;
    d.ansValid = 1'b0;
    d.multiSync = {q.multiSync[0], multiLoopPin};
    // loop states on bits zero to twelve, bit three reserved
    d.status[12:0] = loopFlags;
    d.status[ST_RESERVED_BIT] = 1'b0;
    // heater alarms on single loop, outputs four to six on multi
    d.status[15:ST_UPPER_LSB] = multiLoop ? extraOutputs : heaterAlarms;
    if (q.calBusy && calDone)
    begin
      d.calBusy = 1'b0;
      d.calPassed = calPass;
    end
    // auto-configure only when the new product code matches
    if (moduleSwap)
    begin
      d.autoCfg = (newProductCode == q.product);
      d.product = newProductCode;
    end
    // stored link settings become live only on power cycle
    if (powerCycle)
    begin
      d.addrActive = q.addrStored;
      d.rateActive = q.rateStored;
      d.parActive = q.parStored;
      d.splitActive = q.splitStored;
    end
    if (reqValid && reqWrite && mapped && writable)
    begin
      accept = 1'b1;
      case (reqAddr)
        A_CAL_PHASE:
        begin
          // only phases one to five are taken
          if (reqData >= {13'h0000, CAL_PHASE_MIN} &&
            reqData <= {13'h0000, CAL_PHASE_MAX})
            d.calPhase = reqData[2:0];
          else
            accept = 1'b0;
        end
        A_CAL_KEY:
        begin
          // exact key launches the selected phase
          if (reqData == CAL_KEY_VALUE && !q.calBusy)
          begin
            d.calStart = 1'b1;
            d.calBusy = 1'b1;
            d.calPassed = 1'b0;
          end
          else
            accept = 1'b0;
        end
        // any of the eight baud codes
        A_CFG_BAUD: d.cfgBaud = reqData[2:0];
        A_SLAVE_ADDR:
        begin
          if (reqData >= {8'h00, SLAVE_ADDR_MIN} &&
            reqData <= {8'h00, SLAVE_ADDR_MAX})
            d.addrStored = reqData[7:0];
          else
            accept = 1'b0;
        end
        A_SLAVE_RATE:
        begin
          if (reqData[15:2] == 14'h0000)
            d.rateStored = reqData[1:0];
          else
            accept = 1'b0;
        end
        A_SLAVE_PARITY:
        begin
          if (reqData <= {14'h0000, PAR_ODD})
            d.parStored = reqData[1:0];
          else
            accept = 1'b0;
        end
        A_ASM_SPLIT:
        begin
          // read table length within the shared pool
          if (reqData <= 16'(ASM_ENTRIES))
            d.splitStored = reqData[8:0];
          else
            accept = 1'b0;
        end
        default:
        begin
          // read-table entries belong to the loop side
          if (isAsm && {1'b0, reqAddr[7:0]} < q.splitActive)
            accept = 1'b0;
        end
      endcase
    end
    // answer next cycle, a write echoes its data
    // descriptor writes are refused and change nothing
    if (reqValid)
    begin
      d.ansValid = 1'b1;
      d.ansError = reqWrite ? !accept : !mapped;
      d.ansData = reqWrite ? reqData : (mapped ? rdWord : 16'h0000);
    end
  end

  // Single state register of the bank
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      q <= '0;
      q.calPhase <= CAL_PHASE_RST;
      q.cfgBaud <= BAUD_CODE_RST;
      q.addrStored <= SLAVE_ADDR_RST;
      q.addrActive <= SLAVE_ADDR_RST;
      q.rateStored <= RATE_19200;
      q.rateActive <= RATE_19200;
      q.parStored <= PAR_NONE;
      q.parActive <= PAR_NONE;
      q.splitStored <= ASM_SPLIT_RST;
      q.splitActive <= ASM_SPLIT_RST;
    end
    else
      q <= d;
  end

  cpb_assembly_table #(.DEPTH(ASM_ENTRIES)) assemblyTable (
    .clk(clk),
    .reset(reset),
    .port(asmPort)
  );

  // bit enable runs at the live rate only
  cpb_rate_divider #(
    .C2400(C2400),
    .C4800(C4800),
    .C9600(C9600),
    .C19200(C19200)
  ) rateDivider (
    .clk(clk),
    .reset(reset),
    .rate(q.rateActive),
    .tick(bitTick)
  );

  assign ansValid = q.ansValid;
  assign ansData = q.ansData;
  assign ansError = q.ansError;
  assign calStart = q.calStart;
  assign calPhase = q.calPhase;
  assign autoConfig = q.autoCfg;
  assign slaveAddr = q.addrActive;
  assign slaveRate = q.rateActive;
  assign slaveParity = q.parActive;
  assign asmSplit = q.splitActive;
  assign cfgBaudCode = q.cfgBaud;
endmodule : cpb_parameter_bank
`default_nettype wire

// *** bench/cpb_bank_properties.sv ***
// Concurrent checks on the parameter bank ports
`timescale 1ns/100ps
`default_nettype none
module cpb_bank_properties
  import cpb_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic powerCycle,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [15:0] reqAddr,
  input wire logic [15:0] reqData,
  input wire logic ansValid,
  input wire logic [15:0] ansData,
  input wire logic ansError,
  input wire logic calStart,
  input wire logic [2:0] calPhase,
  input wire logic [7:0] slaveAddr,
  input wire logic [1:0] slaveRate,
  input wire logic [1:0] slaveParity,
  input wire logic [8:0] asmSplit,
  input wire logic [2:0] cfgBaudCode
);
  logic wr;
  logic keyHit;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Write strobes decoded once
  assign wr = reqValid && reqWrite;
  assign keyHit = wr && reqAddr == A_CAL_KEY && reqData == CAL_KEY_VALUE;
  sequence keyThenStart;
    keyHit ##1 calStart;
  endsequence
  a_answer_next: assert property (1'b1 |=> ansValid == $past(reqValid))
    else $error("answer not one cycle after request");
  a_write_echo: assert property (wr |=> ansData == $past(reqData))
    else $error("write answer does not echo data");
  a_no_false_start: assert property (!keyHit |=> !calStart)
    else $error("calibration started without key");
  a_start_pulse: assert property (keyThenStart |=> !calStart)
    else $error("calibration start longer than one cycle");
  a_phase_take: assert property (wr && reqAddr == A_CAL_PHASE
    && reqData >= 16'h0001 && reqData <= 16'h0005
    |=> calPhase == $past(reqData[2:0]))
    else $error("phase write not taken");
  a_phase_range: assert property (calPhase inside {[3'h1:3'h5]})
    else $error("phase out of range");
  a_addr_legal: assert property (slaveAddr inside {[8'h01:8'hF7]})
    else $error("slave address out of range");
  // settings move only on power cycle
  a_settings_hold: assert property (!powerCycle
    |=> $stable({slaveAddr, slaveRate, slaveParity, asmSplit}))
    else $error("link settings changed without power cycle");
  a_parity_legal: assert property (slaveParity != 2'h3)
    else $error("illegal parity code");
  a_ro_refused: assert property (wr && (reqAddr == A_FW_VERSION
    || reqAddr == A_DATABASE_ID) |=> ansError)
    else $error("descriptor write accepted");
  a_baud_apply: assert property (wr && reqAddr == A_CFG_BAUD
    && reqData < 16'h0008 |=> cfgBaudCode == $past(reqData[2:0]))
    else $error("baud code not applied");
endmodule : cpb_bank_properties

bind cpb_parameter_bank cpb_bank_properties u_props (
  .clk(clk), .reset(reset), .powerCycle(powerCycle),
  .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
  .reqData(reqData), .ansValid(ansValid), .ansData(ansData),
  .ansError(ansError), .calStart(calStart), .calPhase(calPhase),
  .slaveAddr(slaveAddr), .slaveRate(slaveRate),
  .slaveParity(slaveParity), .asmSplit(asmSplit),
  .cfgBaudCode(cfgBaudCode)
);
`default_nettype wire

// *** bench/cpb_cal_engine.sv ***
// Calibration engine model beside the parameter bank
`timescale 1ns/100ps
`default_nettype none
module cpb_cal_engine (
  input wire logic clk,
  input wire logic reset,
  input wire logic calStart,
  input wire logic passMode,
  output logic calDone,
  output logic calPass
);
  logic [3:0] waitQ;
  // Result a few cycles after launch; pass flag scrambled off the strobe
  always @(negedge clk or posedge reset)
  begin
    if (reset)
    begin
      waitQ <= 4'h0;
      calDone <= 1'b0;
      calPass <= 1'b0;
    end
    else
    begin
      calDone <= waitQ == 4'h1;
      calPass <= (waitQ == 4'h1) ? passMode : ~calPass;
      if (calStart)
        waitQ <= 4'h5;
      else if (waitQ != 4'h0)
        waitQ <= waitQ - 4'h1;
    end
  end
endmodule : cpb_cal_engine
`default_nettype wire

// *** bench/cpb_parameter_bank_tb_top.sv ***
// Self-checking bench of the parameter bank
`timescale 1ns/100ps
`default_nettype none
module cpb_parameter_bank_tb_top;
  import cpb_pkg::*;
  localparam logic [39:0] LSER = 40'h12_3456_789A;
  localparam logic [39:0] BSER = 40'hE8_D4A5_0FFF;
  // Arbitrary variant value
  localparam logic [15:0] VAR = 16'h0007;
  // Distinct date words so a swapped order shows
  localparam logic [15:0] BDAY = 16'h001F;
  localparam logic [15:0] BMON = 16'h000C;
  localparam logic [15:0] BYR = 16'h07D0;
  localparam logic [4:0] FWREV = 5'h03;
  localparam logic [4:0] FWALP = 5'h02;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic powerCycle, reqValid, reqWrite, moduleSwap, moduleRemoved;
  logic multiLoopPin, loopWrEn, passMode, calDone, calPass;
  logic ansValid, ansError, calStart, autoConfig, bitTick;
  logic ansE, startSeen, acSeen;
  logic [15:0] reqAddr, reqData, newProductCode, loopWrData, ansData, ansD;
  logic [12:0] loopFlags;
  logic [2:0] heaterAlarms, extraOutputs, calPhase, cfgBaudCode;
  logic [7:0] loopWrIdx, slaveAddr;
  logic [1:0] slaveRate, slaveParity;
  logic [8:0] asmSplit;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  int n;
  always #5 clk = ~clk;
  cpb_parameter_bank #(.LOOP_SERIAL(LSER), .BUS_SERIAL(BSER),
    .BUS_DAY(BDAY), .BUS_MONTH(BMON), .BUS_YEAR(BYR),
    .BUS_VARIANT(VAR), .FW_REVISION(FWREV), .FW_ALPHA(FWALP),
    .C2400(8), .C4800(6), .C9600(4), .C19200(2)) DUT (
    .clk(clk), .reset(reset), .powerCycle(powerCycle),
    .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
    .reqData(reqData), .ansValid(ansValid), .ansData(ansData),
    .ansError(ansError), .calStart(calStart), .calPhase(calPhase),
    .calDone(calDone), .calPass(calPass), .loopFlags(loopFlags),
    .heaterAlarms(heaterAlarms), .extraOutputs(extraOutputs),
    .multiLoopPin(multiLoopPin), .moduleSwap(moduleSwap),
    .moduleRemoved(moduleRemoved), .newProductCode(newProductCode),
    .autoConfig(autoConfig), .loopWrEn(loopWrEn), .loopWrIdx(loopWrIdx),
    .loopWrData(loopWrData), .slaveAddr(slaveAddr), .slaveRate(slaveRate),
    .slaveParity(slaveParity), .asmSplit(asmSplit),
    .cfgBaudCode(cfgBaudCode), .bitTick(bitTick));
  cpb_cal_engine u_cal (.clk(clk), .reset(reset), .calStart(calStart),
    .passMode(passMode), .calDone(calDone), .calPass(calPass));
  task chk16(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk16
  task chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk1
  // One access, entered just after a falling edge
  task acc(input logic w, input logic [15:0] a, input logic [15:0] d);
    reqValid = 1'b1;
    reqWrite = w;
    reqAddr = a;
    reqData = d;
    @(negedge clk);
    reqValid = 1'b0;
    ansD = ansData;
    ansE = ansError;
    startSeen = calStart;
    chk1(ansValid, 1'b1);
    @(negedge clk);
  endtask : acc
  task rdchk(input logic [15:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    chk16(ansD, e);
  endtask : rdchk
  task wrchk(input logic [15:0] a, input logic [15:0] d, input logic e);
    acc(1'b1, a, d);
    chk16(ansD, d);
    chk1(ansE, e);
  endtask : wrchk
  // Pulse of loop write, removal, swap or power cycle
  task pulse(input logic [3:0] m);
    {loopWrEn, moduleRemoved, moduleSwap, powerCycle} = m;
    @(negedge clk);
    {loopWrEn, moduleRemoved, moduleSwap, powerCycle} = 4'h0;
    acSeen = autoConfig;
    @(negedge clk);
  endtask : pulse
  // Result wait is bounded so a lost strobe cannot hang the run
  task wait_done;
    for (int i = 0; i < 20 && calDone !== 1'b1; i++)
      @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : wait_done
  task final_report;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report
  // Cycle ceiling well above the sequence length
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      final_report();
    end
  end
  initial
  begin
    {powerCycle, reqValid, reqWrite, moduleSwap, moduleRemoved} = 5'h00;
    {multiLoopPin, loopWrEn, passMode} = 3'h0;
    {reqAddr, reqData, newProductCode, loopWrData} = 64'h0;
    loopWrIdx = 8'h00;
    loopFlags = 13'h1A5F;
    heaterAlarms = 3'h5;
    extraOutputs = 3'h2;
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    rdchk(A_CAL_PHASE, 16'h0001);
    rdchk(A_CAL_KEY, CAL_FAIL_WORD);
    rdchk(A_CFG_BAUD, {13'h0, BAUD_CODE_RST});
    rdchk(A_SLAVE_ADDR, 16'h0060);
    rdchk(16'h01FF, ASM_FILL);
    wrchk(A_LOOP_SERIAL, 16'h0000, 1'b1);
    rdchk(A_LOOP_SERIAL, LSER[15:0]);
    rdchk(A_LOOP_SERIAL + 16'h2, {8'h00, LSER[39:32]});
    rdchk(A_BUS_SERIAL, BSER[15:0]);
    rdchk(A_BUS_SERIAL + 16'h1, BSER[31:16]);
    rdchk(A_BUS_SERIAL + 16'h2, {8'h00, BSER[39:32]});
    rdchk(A_BUS_DATE, BDAY);
    rdchk(A_BUS_DATE + 16'h1, BMON);
    rdchk(A_BUS_DATE + 16'h2, BYR);
    rdchk(16'h0018, 16'h0000);
    chk1(ansE, 1'b1);
    wrchk(A_BUS_VARIANT, 16'h0001, 1'b1);
    rdchk(A_BUS_VARIANT, VAR);
    wrchk(A_DATABASE_ID, 16'h0006, 1'b1);
    rdchk(A_DATABASE_ID, 16'h0001);
    wrchk(A_FW_VERSION, 16'hFFFF, 1'b1);
    rdchk(A_FW_VERSION, 16'h0043);
    rdchk(A_LOOP_STATUS, 16'hBA57);
    multiLoopPin = 1'b1;
    repeat (4) @(negedge clk);
    rdchk(A_FW_VERSION, 16'h0843);
    rdchk(A_LOOP_STATUS, 16'h5A57);
    wrchk(A_CAL_PHASE, 16'h0006, 1'b1);
    wrchk(A_CAL_PHASE, 16'h0000, 1'b1);
    wrchk(A_CAL_PHASE, 16'h0005, 1'b0);
    chk16({13'h0, calPhase}, 16'h0005);
    wrchk(A_CAL_KEY, 16'hCAFF, 1'b1);
    chk1(startSeen, 1'b0);
    for (int i = 1; i >= 0; i--)
    begin
      passMode = i[0];
      wrchk(A_CAL_KEY, CAL_KEY_VALUE, 1'b0);
      chk1(startSeen, 1'b1);
      wait_done();
      rdchk(A_CAL_KEY, i[0] ? CAL_PASS_WORD : CAL_FAIL_WORD);
    end
    for (int i = 0; i < 8; i++)
    begin
      wrchk(A_CFG_BAUD, 16'(i), 1'b0);
      chk16({13'h0, cfgBaudCode}, 16'(i));
    end
    wrchk(16'h0105, 16'h1234, 1'b1);
    wrchk(16'h0180, 16'h4321, 1'b0);
    rdchk(16'h0180, 16'h4321);
    loopWrIdx = 8'h05;
    loopWrData = 16'h5A5A;
    pulse(4'h8);
    rdchk(16'h0105, 16'h5A5A);
    pulse(4'h2);
    chk1(acSeen, 1'b1);
    rdchk(16'h0180, ASM_FILL);
    newProductCode = 16'h0007;
    pulse(4'h2);
    chk1(acSeen, 1'b0);
    rdchk(A_LOOP_PRODUCT, 16'h0007);
    pulse(4'h8);
    pulse(4'h4);
    rdchk(16'h0105, ASM_FILL);
    wrchk(A_ASM_SPLIT, 16'h0101, 1'b1);
    wrchk(A_ASM_SPLIT, 16'h0100, 1'b0);
    wrchk(A_SLAVE_ADDR, 16'h0000, 1'b1);
    wrchk(A_SLAVE_ADDR, 16'h00F8, 1'b1);
    wrchk(A_SLAVE_ADDR, 16'h00F7, 1'b0);
    rdchk(A_SLAVE_ADDR, 16'h00F7);
    wrchk(A_SLAVE_PARITY, 16'h0003, 1'b1);
    wrchk(A_SLAVE_RATE, 16'h0004, 1'b1);
    for (int i = 3; i >= 0; i--)
    begin
      wrchk(A_SLAVE_RATE, 16'(i), 1'b0);
      if (i < 3)
        wrchk(A_SLAVE_PARITY, 16'(2 - i), 1'b0);
    end
    chk16({8'h00, slaveAddr}, 16'h0060);
    chk16({14'h0, slaveRate}, 16'h0003);
    pulse(4'h1);
    chk16({8'h00, slaveAddr}, 16'h00F7);
    chk16({7'h0, asmSplit}, 16'h0100);
    chk16({14'h0, slaveParity}, 16'h0002);
    chk16({14'h0, slaveRate}, 16'h0000);
    rdchk(16'h0180, ASM_FILL);
    // Period measured tick to tick, clear of the rate change
    repeat (20) @(negedge clk);
    for (int i = 0; i < 40 && bitTick !== 1'b1; i++)
      @(negedge clk);
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (bitTick !== 1'b1 && n < 40);
    chk16(16'(n), 16'h0008);
    final_report();
  end
endmodule : cpb_parameter_bank_tb_top
`default_nettype wire
